// File: shared/gpio_pkg.sv
// Purpose: Constants and carrier types for the three-port I/O block
// Assumes: APB slave, 32-bit data, byte address = 4 x register index
// Notes:   Register indices are kept as printed; low byte carries the data
//
// Notes on behaviour
// - Port B direction one tri-states the pin
// - Port B direction zero drives latch value
// - Port C eight bits, one means input
// - Port C direction one tri-states unless overridden
// - Clearing option bit 7 enables pull-ups
// - Pull-up off on output-configured port B pins
// - Option register resets to all ones
// - Only upper-four input pins are compared
// - Compare against reference from last port B access
// - OR of mismatches sets change flag
// - Change flag wakes device from sleep
// - Persisting mismatch keeps setting the flag
// - Port B access refreshes reference; clear flag
// - Port B bit 0 edge-selected interrupt
// - Port A bit 4 timer clock, open-drain
// - Port A bit 5 feeds slave select
// - Port A six bits, upper read zero
// - Analog config field resets to zero
// - Peripheral may force port C direction
// - Per-pin select between latch and peripheral
// - Port A read pins, write latch
// - Port A direction one means input
// - Analog pins read zero after reset
package gpio_pkg;
   localparam logic [7:0]  IDX_PORT_A_PINS   = 8'h05;
   localparam logic [7:0]  IDX_PORT_B_PINS   = 8'h06;
   localparam logic [7:0]  IDX_PORT_C_PINS   = 8'h07;
   localparam logic [7:0]  IDX_INT_CONTROL   = 8'h0b;
   localparam logic [7:0]  IDX_OPTION        = 8'h81;
   localparam logic [7:0]  IDX_PORT_A_DIR    = 8'h85;
   localparam logic [7:0]  IDX_PORT_B_DIR    = 8'h86;
   localparam logic [7:0]  IDX_PORT_C_DIR    = 8'h87;
   localparam logic [7:0]  IDX_ANALOG_CFG    = 8'h9f;
   localparam logic [7:0]  IDX_SLEEP_CTRL    = 8'hc0;
   localparam int          PULLUP_N_BIT      = 7;
   localparam int          EDGE_SEL_BIT      = 6;
   localparam int          CHANGE_FLAG_BIT   = 0;
   localparam int          EXT_FLAG_BIT      = 1;
   localparam int          TIMER_PIN_BIT     = 4;
   localparam int          SLAVE_SEL_BIT     = 5;
   localparam logic [7:0]  OPTION_RESET      = 8'hff;
   localparam logic [5:0]  PORT_A_DIR_RESET  = 6'h3f;
   localparam logic [7:0]  DIR_RESET         = 8'hff;
   localparam logic [2:0]  ANALOG_CFG_RESET  = 3'h0;
   localparam logic [2:0]  ANALOG_ALL_DIGITAL = 3'h6;
   localparam logic [5:0]  PORT_A_ANALOG_MASK = 6'h2f;
   localparam logic [7:0]  CHANGE_PIN_MASK   = 8'hf0;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ACCESS = 2'b01
   } apb_state_t;

   typedef struct packed {
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [7:0] sel;
      logic [7:0] oe;
      logic [7:0] dout;
      logic [7:0] force_out;
      logic [7:0] force_in;
   } periph_c_t;
endpackage : gpio_pkg

// File: core/three_port_gpio_block.sv
// Purpose: Three-port general-purpose I/O with change and edge interrupts
// Assumes: One clock, APB register access, pins synchronised on entry
// Notes:   Output enables are active low; a pin is driven when its enable is 0
`timescale 1ns/100ps
`default_nettype none
module three_port_gpio_block (
   input  wire logic                clk_sys,
   input  wire logic                resetn,
   input  wire gpio_pkg::apb_req_t  apb_req,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [5:0]          port_a_in,
   output logic [5:0]               port_a_out,
   output logic [5:0]               port_a_oe_n,
   input  wire logic [7:0]          port_b_in,
   output logic [7:0]               port_b_out,
   output logic [7:0]               port_b_oe_n,
   output logic [7:0]               port_b_pullup_en,
   input  wire logic [7:0]          port_c_in,
   output logic [7:0]               port_c_out,
   output logic [7:0]               port_c_oe_n,
   input  wire gpio_pkg::periph_c_t periph_c,
   output logic                     timer_ext_clock,
   output logic                     slave_select_n,
   output logic [2:0]               analog_cfg_field,
   output logic                     port_change_irq,
   output logic                     ext_interrupt_irq,
   output logic                     wake_up
);
   logic [5:0] a_meta_reg, a_sync_reg;
   logic [7:0] b_meta_reg, b_sync_reg, c_meta_reg, c_sync_reg;
   logic [5:0] a_latch_reg, a_dir_reg;
   logic [7:0] b_latch_reg, b_dir_reg, c_latch_reg, c_dir_reg;
   logic [7:0] option_reg;
   logic [2:0] analog_reg;
   logic [7:0] ref_reg;
   logic       change_flag_reg, ext_flag_reg, ext_prev_reg, asleep_reg;
   gpio_pkg::apb_state_t state_reg;
   logic [7:0] idx;
   logic       wr_en, rd_en, acc_en;
   logic [7:0] rdata_next;
   logic       hit;
   logic [5:0] a_digital;
   logic [7:0] c_dir_eff, c_out_eff;
   logic [3:0] mismatch;
   logic       any_mismatch, ext_edge;
   logic       chg_clear, ext_clear, b_access;

   // Pins from outside pass two flops before any logic reads them
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         a_meta_reg <= 6'h00;
         a_sync_reg <= 6'h00;
         b_meta_reg <= 8'h00;
         b_sync_reg <= 8'h00;
         c_meta_reg <= 8'h00;
         c_sync_reg <= 8'h00;
      end else begin
         a_meta_reg <= port_a_in;
         a_sync_reg <= a_meta_reg;
         b_meta_reg <= port_b_in;
         b_sync_reg <= b_meta_reg;
         c_meta_reg <= port_c_in;
         c_sync_reg <= c_meta_reg;
      end
   end

   // APB: setup, then one access cycle with pready high
   assign idx    = apb_req.paddr[9:2];
   assign acc_en = apb_req.psel && apb_req.penable && state_reg == gpio_pkg::ST_ACCESS;
   assign wr_en  = acc_en && apb_req.pwrite;
   assign rd_en  = acc_en && !apb_req.pwrite;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg <= gpio_pkg::ST_IDLE;
      end else begin
         case (state_reg)
            gpio_pkg::ST_IDLE: begin
               if (apb_req.psel && !apb_req.penable) begin
                  state_reg <= gpio_pkg::ST_ACCESS;
               end
            end
            gpio_pkg::ST_ACCESS: begin
               state_reg <= gpio_pkg::ST_IDLE;
            end
            default: begin
               state_reg <= gpio_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Analog-configured port A pins read zero; codes 6 and 7 make all digital
   always_comb begin
      a_digital = a_sync_reg;
      if (analog_reg != gpio_pkg::ANALOG_ALL_DIGITAL && analog_reg != 3'h7) begin
         a_digital = a_sync_reg & ~gpio_pkg::PORT_A_ANALOG_MASK;
      end
   end

   always_comb begin
      rdata_next = 8'h00;
      hit        = 1'b1;
      case (idx)
         gpio_pkg::IDX_PORT_A_PINS: rdata_next = {2'b00, a_digital};
         gpio_pkg::IDX_PORT_B_PINS: rdata_next = b_sync_reg;
         gpio_pkg::IDX_PORT_C_PINS: rdata_next = c_sync_reg;
         gpio_pkg::IDX_INT_CONTROL: rdata_next = {6'h00, ext_flag_reg, change_flag_reg};
         gpio_pkg::IDX_OPTION:      rdata_next = option_reg;
         gpio_pkg::IDX_PORT_A_DIR:  rdata_next = {2'b00, a_dir_reg};
         gpio_pkg::IDX_PORT_B_DIR:  rdata_next = b_dir_reg;
         gpio_pkg::IDX_PORT_C_DIR:  rdata_next = c_dir_reg;
         gpio_pkg::IDX_ANALOG_CFG:  rdata_next = {5'h00, analog_reg};
         gpio_pkg::IDX_SLEEP_CTRL:  rdata_next = {7'h00, asleep_reg};
         default:                   hit = 1'b0;
      endcase
      if (apb_req.paddr[11:10] != 2'b00 || apb_req.paddr[1:0] != 2'b00) begin
         hit = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= apb_req.psel && !apb_req.penable;
         pslverr <= apb_req.psel && !apb_req.penable && !hit;
         prdata  <= (apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit)
                    ? {24'h00_0000, rdata_next} : 32'h0000_0000;
      end
   end

   // Writes land only on the access edge of a decoded address
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         a_latch_reg <= 6'h00;
         b_latch_reg <= 8'h00;
         c_latch_reg <= 8'h00;
         a_dir_reg   <= gpio_pkg::PORT_A_DIR_RESET;
         b_dir_reg   <= gpio_pkg::DIR_RESET;
         c_dir_reg   <= gpio_pkg::DIR_RESET;
         option_reg  <= gpio_pkg::OPTION_RESET;
         analog_reg  <= gpio_pkg::ANALOG_CFG_RESET;
      end else if (wr_en && pslverr == 1'b0) begin
         case (idx)
            gpio_pkg::IDX_PORT_A_PINS: a_latch_reg <= apb_req.pwdata[5:0];
            gpio_pkg::IDX_PORT_B_PINS: b_latch_reg <= apb_req.pwdata[7:0];
            gpio_pkg::IDX_PORT_C_PINS: c_latch_reg <= apb_req.pwdata[7:0];
            gpio_pkg::IDX_OPTION:      option_reg  <= apb_req.pwdata[7:0];
            gpio_pkg::IDX_PORT_A_DIR:  a_dir_reg   <= apb_req.pwdata[5:0];
            gpio_pkg::IDX_PORT_B_DIR:  b_dir_reg   <= apb_req.pwdata[7:0];
            gpio_pkg::IDX_PORT_C_DIR:  c_dir_reg   <= apb_req.pwdata[7:0];
            gpio_pkg::IDX_ANALOG_CFG:  analog_reg  <= apb_req.pwdata[2:0];
            default: begin
            end
         endcase
      end
   end

   // Port C: peripheral select takes output; forced direction overrides the register
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         c_out_eff[i] = periph_c.sel[i] ? periph_c.dout[i] : c_latch_reg[i];
         c_dir_eff[i] = c_dir_reg[i];
         if (periph_c.sel[i]) begin
            c_dir_eff[i] = ~periph_c.oe[i];
         end
         if (periph_c.force_out[i]) begin
            c_dir_eff[i] = 1'b0;
         end else if (periph_c.force_in[i]) begin
            c_dir_eff[i] = 1'b1;
         end
      end
   end

   // Pin drivers; enables are active low so a direction of one means released
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         port_a_out       <= 6'h00;
         port_a_oe_n      <= 6'h3f;
         port_b_out       <= 8'h00;
         port_b_oe_n      <= 8'hff;
         port_b_pullup_en <= 8'h00;
         port_c_out       <= 8'h00;
         port_c_oe_n      <= 8'hff;
      end else begin
         port_a_out <= a_latch_reg;
         port_a_oe_n <= a_dir_reg;
         // Open drain: the timer pin may pull low but never drives high
         port_a_out[gpio_pkg::TIMER_PIN_BIT]  <= 1'b0;
         port_a_oe_n[gpio_pkg::TIMER_PIN_BIT] <= a_dir_reg[gpio_pkg::TIMER_PIN_BIT]
                                                 | a_latch_reg[gpio_pkg::TIMER_PIN_BIT];
         port_b_out  <= b_latch_reg;
         port_b_oe_n <= b_dir_reg;
         port_b_pullup_en <= b_dir_reg & {8{~option_reg[gpio_pkg::PULLUP_N_BIT]}};
         port_c_out  <= c_out_eff;
         port_c_oe_n <= c_dir_eff;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         timer_ext_clock  <= 1'b0;
         slave_select_n   <= 1'b1;
         analog_cfg_field <= gpio_pkg::ANALOG_CFG_RESET;
      end else begin
         timer_ext_clock  <= a_sync_reg[gpio_pkg::TIMER_PIN_BIT];
         slave_select_n   <= a_sync_reg[gpio_pkg::SLAVE_SEL_BIT];
         analog_cfg_field <= analog_reg;
      end
   end

   // Change detection against the reference caught at the last port B access
   assign b_access     = acc_en && idx == gpio_pkg::IDX_PORT_B_PINS;
   assign mismatch     = (b_sync_reg[7:4] ^ ref_reg[7:4]) & b_dir_reg[7:4];
   assign any_mismatch = |mismatch;
   assign ext_edge     = option_reg[gpio_pkg::EDGE_SEL_BIT]
                         ? (b_sync_reg[0] && !ext_prev_reg)
                         : (!b_sync_reg[0] && ext_prev_reg);
   assign chg_clear    = wr_en && idx == gpio_pkg::IDX_INT_CONTROL
                         && !apb_req.pwdata[gpio_pkg::CHANGE_FLAG_BIT];
   assign ext_clear    = wr_en && idx == gpio_pkg::IDX_INT_CONTROL
                         && !apb_req.pwdata[gpio_pkg::EXT_FLAG_BIT];

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ref_reg <= 8'h00;
      end else if (b_access) begin
         ref_reg <= b_sync_reg & gpio_pkg::CHANGE_PIN_MASK;
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         change_flag_reg <= 1'b0;
      end else if (any_mismatch && !b_access) begin
         change_flag_reg <= 1'b1;
      end else if (chg_clear) begin
         change_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ext_prev_reg <= 1'b0;
         ext_flag_reg <= 1'b0;
      end else begin
         ext_prev_reg <= b_sync_reg[0];
         if (ext_edge) begin
            ext_flag_reg <= 1'b1;
         end else if (ext_clear) begin
            ext_flag_reg <= 1'b0;
         end
      end
   end

   // Sleep entered by software, left on a port change
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         asleep_reg        <= 1'b0;
         wake_up           <= 1'b0;
         port_change_irq   <= 1'b0;
         ext_interrupt_irq <= 1'b0;
      end else begin
         port_change_irq   <= change_flag_reg;
         ext_interrupt_irq <= ext_flag_reg;
         wake_up           <= asleep_reg && change_flag_reg;
         if (asleep_reg && change_flag_reg) begin
            asleep_reg <= 1'b0;
         end else if (wr_en && idx == gpio_pkg::IDX_SLEEP_CTRL) begin
            asleep_reg <= apb_req.pwdata[0];
         end
      end
   end

   a_pull_off: assert property (@(posedge clk_sys) disable iff (!resetn)
      option_reg[gpio_pkg::PULLUP_N_BIT] |=> port_b_pullup_en == 8'h00)
      else $error("pull-ups on while disabled");
   a_pull_output: assert property (@(posedge clk_sys) disable iff (!resetn)
      1'b1 |=> (port_b_pullup_en & ~$past(b_dir_reg)) == 8'h00)
      else $error("pull-up on an output pin");
   a_b_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
      1'b1 |=> port_b_oe_n == $past(b_dir_reg) && port_b_out == $past(b_latch_reg))
      else $error("port B driver mismatch");
   a_open_drain: assert property (@(posedge clk_sys) disable iff (!resetn)
      !port_a_oe_n[gpio_pkg::TIMER_PIN_BIT] |-> !port_a_out[gpio_pkg::TIMER_PIN_BIT])
      else $error("timer pin driven high");
   a_change_set: assert property (@(posedge clk_sys) disable iff (!resetn)
      any_mismatch && !b_access |=> change_flag_reg)
      else $error("mismatch did not set flag");
   a_out_excluded: assert property (@(posedge clk_sys) disable iff (!resetn)
      b_dir_reg[7:4] == 4'h0 |-> !any_mismatch)
      else $error("output pin compared");
   a_ref_update: assert property (@(posedge clk_sys) disable iff (!resetn)
      b_access |=> ref_reg[7:4] == $past(b_sync_reg[7:4]))
      else $error("reference not refreshed");
   a_c_force: assert property (@(posedge clk_sys) disable iff (!resetn)
      periph_c.force_out[2] |=> !port_c_oe_n[2])
      else $error("force out ignored");
   a_c_tristate: assert property (@(posedge clk_sys) disable iff (!resetn)
      c_dir_reg[7] && !periph_c.sel[7] && !periph_c.force_out[7] ##1 1'b1 |-> port_c_oe_n[7])
      else $error("port C not released");
   a_wake: assert property (@(posedge clk_sys) disable iff (!resetn)
      asleep_reg && change_flag_reg |=> wake_up && !asleep_reg)
      else $error("no wake on change");
   a_edge_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
      ext_edge |=> ext_flag_reg)
      else $error("edge not flagged");
endmodule : three_port_gpio_block
`default_nettype wire

// File: verification/pin_board.sv
// Purpose: Board-side model of one port: resolves each pin from the block, the bench driver and pull-ups
// Assumes: The block's output enable is active low; the bench drives only the pins it enables
// Notes:   A line nobody drives or pulls toggles each cycle
`timescale 1ns/100ps
`default_nettype none
module pin_board #(
   parameter int W = 8
) (
   input  wire logic         clk_sys,
   input  wire logic [W-1:0] dut_out,
   input  wire logic [W-1:0] dut_oe_n,
   input  wire logic [W-1:0] pull_en,
   input  wire logic [W-1:0] ext_en,
   input  wire logic [W-1:0] ext_val,
   output logic      [W-1:0] pin
);
   logic [W-1:0] float_q;
   initial float_q = '0;
   // Toggling stops a floating line from passing for a stable level
   always @(posedge clk_sys) float_q <= ~float_q;
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (dut_oe_n[i] == 1'b0) pin[i] = dut_out[i];
         else if (ext_en[i]) pin[i] = ext_val[i];
         else if (pull_en[i]) pin[i] = 1'b1;
         else pin[i] = float_q[i];
      end
   end
endmodule : pin_board
`default_nettype wire

// File: verification/test_three_port_gpio_block.sv
// Purpose: Self-checking bench for the three-port I/O block
// Assumes: Zero-wait APB slave, two-flop pin synchronisers
// Notes:   Pins are resolved by pin_board instances
`timescale 1ns/100ps
`default_nettype none
module test_three_port_gpio_block;
   logic clk_sys = 1'b0;
   logic resetn  = 1'b0;
   gpio_pkg::apb_req_t  apb_req = '0;
   gpio_pkg::periph_c_t periph_c = '0;
   logic [31:0] prdata;
   logic        pready, pslverr, timer_ext_clock, slave_select_n;
   logic        port_change_irq, ext_interrupt_irq, wake_up;
   logic [2:0]  analog_cfg_field;
   logic [5:0]  a_in, a_out, a_oe_n;
   logic [5:0]  a_en = '0, a_val = '0;
   logic [7:0]  b_in, b_out, b_oe_n, b_pu, c_in, c_out, c_oe_n;
   logic [7:0]  b_en = '0, b_val = '0, c_en = '0, c_val = '0;
   logic [31:0] rd;
   logic        err;
   int          fail_count = 0;
   int          n_compared = 0;
   int          wake_cnt = 0;

   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (wake_up === 1'b1) wake_cnt++;

   three_port_gpio_block u_dut (.clk_sys(clk_sys), .resetn(resetn), .apb_req(apb_req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .port_a_in(a_in), .port_a_out(a_out), .port_a_oe_n(a_oe_n),
      .port_b_in(b_in), .port_b_out(b_out), .port_b_oe_n(b_oe_n), .port_b_pullup_en(b_pu),
      .port_c_in(c_in), .port_c_out(c_out), .port_c_oe_n(c_oe_n), .periph_c(periph_c),
      .timer_ext_clock(timer_ext_clock), .slave_select_n(slave_select_n), .analog_cfg_field(analog_cfg_field),
      .port_change_irq(port_change_irq), .ext_interrupt_irq(ext_interrupt_irq), .wake_up(wake_up));
   pin_board #(.W(6)) u_pa (.clk_sys(clk_sys), .dut_out(a_out), .dut_oe_n(a_oe_n), .pull_en(6'h00),
      .ext_en(a_en), .ext_val(a_val), .pin(a_in));
   pin_board #(.W(8)) u_pb (.clk_sys(clk_sys), .dut_out(b_out), .dut_oe_n(b_oe_n), .pull_en(b_pu),
      .ext_en(b_en), .ext_val(b_val), .pin(b_in));
   pin_board #(.W(8)) u_pc (.clk_sys(clk_sys), .dut_out(c_out), .dut_oe_n(c_oe_n), .pull_en(8'h00),
      .ext_en(c_en), .ext_val(c_val), .pin(c_in));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk

   // Holds the request until pready is seen high at a rising edge, giving up after 50 cycles
   task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk_sys);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'b00, idx, 2'b00}, pwdata: {24'h0, wd}};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd  = prdata;
      err = pslverr;
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
      if (n >= 50) chk(1'b0, 1'b1, "pready timeout");
   endtask : xfer

   task automatic settle();
      repeat (5) @(posedge clk_sys);
      #1;
   endtask : settle

   task automatic t_reset();
      xfer(gpio_pkg::IDX_OPTION, 1'b0, 8'h00);     chk(rd, 32'hff, "option");
      xfer(gpio_pkg::IDX_PORT_A_DIR, 1'b0, 8'h00); chk(rd, 32'h3f, "dir a");
      xfer(gpio_pkg::IDX_PORT_B_DIR, 1'b0, 8'h00); chk(rd, 32'hff, "dir b");
      xfer(gpio_pkg::IDX_PORT_C_DIR, 1'b0, 8'h00); chk(rd, 32'hff, "dir c");
      xfer(gpio_pkg::IDX_ANALOG_CFG, 1'b0, 8'h00); chk(rd, 32'h00, "analog");
      chk(b_pu, 8'h00, "pullups");
      chk({a_oe_n, b_oe_n, c_oe_n}, 22'h3fffff, "oe reset");
      xfer(8'h33, 1'b0, 8'h00); chk(err, 1'b1, "unmapped");
      $display("test reset done");
   endtask : t_reset

   task automatic t_port_b();
      xfer(gpio_pkg::IDX_PORT_B_PINS, 1'b1, 8'ha5);
      xfer(gpio_pkg::IDX_PORT_B_DIR, 1'b1, 8'h0f);
      xfer(gpio_pkg::IDX_OPTION, 1'b1, 8'h7f);
      settle();
      chk(b_oe_n, 8'h0f, "b oe");
      chk(b_out & 8'hf0, 8'ha0, "b out");
      chk(b_pu, 8'h0f, "b pull");
      $display("test port b done");
   endtask : t_port_b

   task automatic t_change();
      b_en <= 8'hff;
      b_val <= 8'h00;
      xfer(gpio_pkg::IDX_PORT_B_DIR, 1'b1, 8'hff);
      settle();
      xfer(gpio_pkg::IDX_PORT_B_PINS, 1'b0, 8'h00);
      xfer(gpio_pkg::IDX_INT_CONTROL, 1'b1, 8'h00);
      xfer(gpio_pkg::IDX_SLEEP_CTRL, 1'b1, 8'h01);
      b_val <= 8'h40;
      settle();
      chk(port_change_irq, 1'b1, "change set");
      chk(wake_cnt, 1, "wake");
      xfer(gpio_pkg::IDX_INT_CONTROL, 1'b1, 8'h02);
      settle();
      chk(port_change_irq, 1'b1, "persist");
      xfer(gpio_pkg::IDX_PORT_B_PINS, 1'b0, 8'h00);
      xfer(gpio_pkg::IDX_INT_CONTROL, 1'b1, 8'h02);
      settle();
      chk(port_change_irq, 1'b0, "cleared");
      b_val <= 8'h48;
      settle();
      chk(port_change_irq, 1'b0, "low bits");
      xfer(gpio_pkg::IDX_PORT_B_DIR, 1'b1, 8'h7f);
      xfer(gpio_pkg::IDX_PORT_B_PINS, 1'b1, 8'h80);
      settle();
      chk(port_change_irq, 1'b0, "output pin");
      $display("test change done");
   endtask : t_change

   task automatic t_edge();
      xfer(gpio_pkg::IDX_OPTION, 1'b1, 8'hff);
      xfer(gpio_pkg::IDX_INT_CONTROL, 1'b1, 8'h01);
      b_val[0] <= 1'b1;
      settle();
      chk(ext_interrupt_irq, 1'b1, "rising");
      xfer(gpio_pkg::IDX_OPTION, 1'b1, 8'hbf);
      xfer(gpio_pkg::IDX_INT_CONTROL, 1'b1, 8'h01);
      settle();
      chk(ext_interrupt_irq, 1'b0, "edge clear");
      b_val[0] <= 1'b0;
      settle();
      chk(ext_interrupt_irq, 1'b1, "falling");
      $display("test edge done");
   endtask : t_edge

   task automatic t_port_a();
      a_en <= 6'h3f;
      a_val <= 6'h2f;
      settle();
      xfer(gpio_pkg::IDX_PORT_A_PINS, 1'b0, 8'h00); chk(rd, 32'h00, "analog read");
      chk(slave_select_n, 1'b1, "ss");
      a_val <= 6'h1f;
      xfer(gpio_pkg::IDX_ANALOG_CFG, 1'b1, 8'h06);
      settle();
      xfer(gpio_pkg::IDX_PORT_A_PINS, 1'b0, 8'h00); chk(rd, 32'h1f, "digital read");
      chk({timer_ext_clock, slave_select_n}, 2'b10, "tclk ss");
      chk(analog_cfg_field, 3'h6, "analog field");
      xfer(gpio_pkg::IDX_PORT_A_DIR, 1'b1, 8'hff); chk(err, 1'b0, "dir a wr");
      xfer(gpio_pkg::IDX_PORT_A_DIR, 1'b0, 8'h00); chk(rd, 32'h3f, "dir a six");
      xfer(gpio_pkg::IDX_PORT_A_PINS, 1'b1, 8'h01);
      xfer(gpio_pkg::IDX_PORT_A_DIR, 1'b1, 8'h2e);
      settle();
      chk({a_oe_n, a_out[4], a_out[0]}, 8'hb9, "drain low");
      xfer(gpio_pkg::IDX_PORT_A_PINS, 1'b1, 8'h10);
      settle();
      chk(a_oe_n[4], 1'b1, "drain high");
      $display("test port a done");
   endtask : t_port_a

   task automatic t_port_c();
      c_en <= 8'hff;
      xfer(gpio_pkg::IDX_PORT_C_PINS, 1'b1, 8'h3c);
      xfer(gpio_pkg::IDX_PORT_C_DIR, 1'b1, 8'h00);
      periph_c <= '{sel: 8'h0f, oe: 8'h05, dout: 8'h0a, force_out: 8'h00, force_in: 8'h01};
      settle();
      chk({c_out, c_oe_n}, 16'h3a0b, "periph sel");
      xfer(gpio_pkg::IDX_PORT_C_DIR, 1'b1, 8'hff);
      periph_c <= '{sel: 8'h00, oe: 8'h00, dout: 8'h00, force_out: 8'h40, force_in: 8'h00};
      settle();
      chk(c_oe_n, 8'hbf, "force out");
      $display("test port c done");
   endtask : t_port_c

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      wrap_up();
   end

   initial begin
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset();
      t_port_b();
      t_change();
      t_edge();
      t_port_a();
      t_port_c();
      wrap_up();
   end
endmodule : test_three_port_gpio_block
`default_nettype wire
